// [lcd_ctl.sv]
// lens coil driver control: power modes, i2c register slave, drive timing
`timescale 1ns/1ps
`include "lcd_regs.svh"
// Notes on behaviour
// - scl low 0.5 ms enters shutdown
// - scl rise in shutdown: standby, defaults loaded
// - shutdown holds while scl low, bus ignored
// - nonzero coil current setting enters active
// - zero setting means standby, registers writable
// - soft reset: standby and register defaults
// - faults while active force standby
// - fault entry to standby clears current setting
// - re-entering active clears fault flags
// - output stage enabled only when active
// - drive-style bit picks linear or switched
// - switched: high side, then freewheel, selectable
// - 10-bit reference code from current setting
// - setting changes applied as shaped ramp
// - resonance register tunes ramp timing
// - i2c slave with auto-increment pointer
// - write: address, register, data, each acked
// - acked write data advances pointer
// - read via repeated start returns data
// - read without register uses current pointer
// - drive-style 0 switched, 1 linear
// - sequential bytes advance pointer each time
// - setting applied on low byte write only
module lcd_ctl #(
  parameter int unsigned SHDN_CYC = `SHDN_CYC,
  parameter logic [6:0]  DEV_ADDR = 7'h0E  // arbitrary bus address
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             scl_clk,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output wire logic             sda_o,
  output wire logic             sda_oe,
  input  wire logic             ot_fault_i,
  input  wire logic             short_fault_i,
  input  wire logic             open_fault_i,
  input  wire logic             uvlo_i,
  input  wire logic             ovc_i,
  input  wire logic             cur_above_i,
  output wire logic             drive_en,
  output wire logic             lin_mode,
  output wire logic             hs_on,
  output wire logic             ls_on,
  output wire logic [9:0]       dac_code,
  output lcd_pkg::lcd_pwr_t     pwr_state
);
  import lcd_pkg::*;

  localparam int CW = $clog2(SHDN_CYC + 1);

  lcd_pwr_t   pwr_q;
  lcd_i2c_t   ist_q;
  logic [8:0] s1_q, s2_q;
  logic       scl_p_q, sda_p_q, tg_p_q;
  logic [7:0] sh_q;
  logic       tg_q;
  logic [CW-1:0] low_q;
  logic [3:0] bits_q;
  logic [1:0] byte_q;
  logic       rw_q, oe_q;
  logic [7:0] ptr_q, tx_q;
  logic       ctrl_q;
  logic [1:0] msb_q;
  logic [9:0] coil_q, dac_q, step_q;
  logic [4:0] mode_q, stat_q;
  logic [7:0] res_q;
  logic [5:0] pcnt_q;
  logic       hs_q, ls_q;
  logic [14:0] rcnt_q;

  // absolute distance between two current codes
  function automatic logic [9:0] lcd_dist(input logic [9:0] a, input logic [9:0] b);
    lcd_dist = (a > b) ? a - b : b - a;
  endfunction : lcd_dist

  // switching period in core cycles; unused codes fall back to the slowest
  function automatic logic [5:0] lcd_per(input logic [2:0] f);
    case (f)
      3'h1:    lcd_per = `PWM_1M;
      3'h3:    lcd_per = `PWM_2M;
      3'h5:    lcd_per = `PWM_4M8;
      3'h6:    lcd_per = `PWM_6M;
      3'h7:    lcd_per = `PWM_4M;
      default: lcd_per = `PWM_500K;
    endcase
  endfunction : lcd_per

  // link side: capture bits on rising scl; sh_q then holds still for a
  // whole bit time, long enough for the core to read it after the toggle
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= 8'h00;
      tg_q <= 1'b0;
    end
    else
    begin
      sh_q <= {sh_q[6:0], sda_i};
      tg_q <= ~tg_q;
    end
  end

  // two-stage synchronisers for pins and the bit toggle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
      tg_p_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= {cur_above_i, ot_fault_i, short_fault_i, open_fault_i, uvlo_i, ovc_i,
               tg_q, sda_i, scl_i};
      s2_q <= s1_q;
      scl_p_q <= s2_q[0];
      sda_p_q <= s2_q[1];
      tg_p_q <= s2_q[2];
    end
  end

  // bus events and register decode
  wire       scl_s     = s2_q[0];
  wire       sda_s     = s2_q[1];
  wire       bit_ev    = s2_q[2] ^ tg_p_q;
  wire [4:0] evt_s     = s2_q[7:3];  // tsd, short, open, uvlo, overcurrent
  wire       tsd_s     = s2_q[7];
  wire       fault_s   = |s2_q[7:5];
  wire       cmp_s     = s2_q[8];
  wire       scl_fall  = ~scl_s & scl_p_q;
  wire       start_ev  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire       stop_ev   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire       byte_done = (ist_q == I_RX) & bit_ev & (bits_q == `BYTE_LAST);
  wire       addr_ok   = sh_q[7:1] == DEV_ADDR;
  wire       wr_ev     = byte_done & (byte_q == `BYTE_DATA) & ~rw_q;
  wire       srst_ev   = wr_ev & (ptr_q == `REG_CTRL) & sh_q[`CTRL_RST_BIT];
  wire       lsb_ev    = wr_ev & (ptr_q == `REG_CLSB);
  wire       shdn_ev   = ~scl_s & (low_q == CW'(SHDN_CYC - 1));
  wire       wake_ev   = (pwr_q == LCD_SHDN) & scl_s;
  wire       go_act    = ~shdn_ev & (pwr_q == LCD_STBY) & (coil_q != `CUR_ZERO) & ~tsd_s;
  wire       flt_clr   = (pwr_q == LCD_ACT) & fault_s;
  wire       go_stby   = (pwr_q == LCD_ACT) & (fault_s | srst_ev | coil_q == `CUR_ZERO);
  wire       load_def  = wake_ev | srst_ev;
  wire [9:0] new_cur   = {msb_q, sh_q};
  wire [9:0] new_dist  = lcd_dist(new_cur, dac_q) >> `RAMP_SHIFT;
  wire [9:0] gap       = lcd_dist(coil_q, dac_q);
  wire [9:0] mv        = (gap < step_q) ? gap : step_q;
  wire [8:0] res_span  = `RES_OFS - {1'b0, res_q};
  wire [5:0] ramp_k    = mode_q[`MODE_RMODE_BIT] ? `RAMP_1X : `RAMP_2X;
  wire [14:0] ramp_iv  = {6'h00, res_span} * {9'h000, ramp_k};
  wire [5:0] per       = lcd_per(mode_q[`MODE_FRQ]);
  wire       sw_run    = (pwr_q == LCD_ACT) & ~mode_q[`MODE_LIN_BIT];
  wire [7:0] rdata     = (ptr_q == `REG_CTRL) ? {6'h00, ctrl_q, 1'b0} :
                         (ptr_q == `REG_CMSB) ? {6'h00, msb_q} :
                         (ptr_q == `REG_CLSB) ? coil_q[7:0] :
                         (ptr_q == `REG_STAT) ? {3'h0, stat_q} :
                         (ptr_q == `REG_MODE) ? {3'h0, mode_q} :
                         (ptr_q == `REG_RES)  ? res_q : 8'h00;

  // power mode; a long scl low beats every other transition
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_q <= LCD_SHDN;
      low_q <= '0;
    end
    else if (ce)
    begin
      low_q <= (scl_s || shdn_ev) ? low_q & {CW{~scl_s}} : low_q + CW'(1);
      if (shdn_ev)
        pwr_q <= LCD_SHDN;
      else if (wake_ev)
        pwr_q <= LCD_STBY;
      else if (go_act)
        pwr_q <= LCD_ACT;
      else if (go_stby)
        pwr_q <= LCD_STBY;
    end
  end

  // register file; the current setting only takes a written value on a low byte write, and faults or defaults clear it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `CTRL_DEF;
      msb_q <= 2'h0;
      coil_q <= `CUR_ZERO;
      mode_q <= `MODE_DEF;
      res_q <= `RES_DEF;
      step_q <= 10'h001;
    end
    else if (ce)
    begin
      if (load_def)
      begin
        ctrl_q <= `CTRL_DEF;
        msb_q <= 2'h0;
        coil_q <= `CUR_ZERO;
        mode_q <= `MODE_DEF;
        res_q <= `RES_DEF;
      end
      else if (flt_clr)
      begin
        msb_q <= 2'h0;
        coil_q <= `CUR_ZERO;
      end
      else if (wr_ev)
      begin
        case (ptr_q)
          `REG_CTRL: ctrl_q <= sh_q[`CTRL_RING_BIT];
          `REG_CMSB: msb_q <= sh_q[1:0];
          `REG_CLSB: coil_q <= new_cur;
          `REG_MODE: mode_q <= sh_q[4:0];
          `REG_RES:  res_q <= sh_q;
          default:   ;
        endcase
      end
      if (lsb_ev)
        step_q <= (new_dist == `CUR_ZERO) ? 10'h001 : new_dist;
    end
  end

  // status flags latch; a fault in the clearing cycle still sets
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= 5'h00;
    else if (ce)
      stat_q <= ((go_act || load_def) ? 5'h00 : stat_q) | evt_s;
  end

  // i2c slave engine; it sits idle through shutdown
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_q <= I_IDLE;
      bits_q <= 4'h0;
      byte_q <= 2'h0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
    end
    else if (ce)
    begin
      if (pwr_q == LCD_SHDN || stop_ev)
      begin
        ist_q <= I_IDLE;
        oe_q <= 1'b0;
      end
      else if (start_ev)
      begin
        ist_q <= I_RX;
        bits_q <= 4'h0;
        byte_q <= 2'h0;
        oe_q <= 1'b0;
      end
      else
      begin
        case (ist_q)
          I_RX:
            if (bit_ev)
            begin
              bits_q <= bits_q + 4'h1;
              if (bits_q == `BYTE_LAST)
              begin
                ist_q <= I_ACKW;
                if (byte_q == 2'h0)
                begin
                  rw_q <= sh_q[0];
                  if (!addr_ok)
                    ist_q <= I_IDLE;
                end
                else if (byte_q == 2'h1)
                  ptr_q <= sh_q;
                else
                  ptr_q <= ptr_q + 8'h01;
                if (byte_q != `BYTE_DATA)
                  byte_q <= byte_q + 2'h1;
              end
            end
          I_ACKW:
            if (scl_fall)
            begin
              oe_q <= 1'b1;
              ist_q <= I_ACK;
            end
          I_ACK, I_NXT:
            if (scl_fall)
            begin
              bits_q <= 4'h0;
              if (rw_q)
              begin
                tx_q <= rdata;
                oe_q <= ~rdata[7];
                ist_q <= I_TX;
              end
              else
              begin
                oe_q <= 1'b0;
                ist_q <= I_RX;
              end
            end
          I_TX:
            if (bit_ev)
              bits_q <= bits_q + 4'h1;
            else if (scl_fall)
            begin
              if (bits_q == `BYTE_BITS)
              begin
                oe_q <= 1'b0;
                ist_q <= I_TACK;
              end
              else
                oe_q <= ~tx_q[3'h7 - bits_q[2:0]];
            end
          I_TACK:
            if (bit_ev)
            begin
              if (!sh_q[0])
              begin
                ptr_q <= ptr_q + 8'h01;
                ist_q <= I_NXT;
              end
              else
                ist_q <= I_IDLE;
            end
          default:
            ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // switched drive: high side at period start, freewheel once current is up
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcnt_q <= 6'h00;
      hs_q <= 1'b0;
      ls_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!sw_run)
      begin
        pcnt_q <= 6'h00;
        hs_q <= 1'b0;
        ls_q <= 1'b0;
      end
      else if (pcnt_q >= per - 6'h01)
      begin
        pcnt_q <= 6'h00;
        hs_q <= 1'b1;
        ls_q <= 1'b0;
      end
      else
      begin
        pcnt_q <= pcnt_q + 6'h01;
        if (hs_q && cmp_s)
        begin
          hs_q <= 1'b0;
          ls_q <= 1'b1;
        end
      end
    end
  end

  // reference ramp; each step takes 1/64 of the jump so the move spans
  // roughly one or two resonance periods
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_q <= `CUR_ZERO;
      rcnt_q <= 15'h0000;
    end
    else if (ce)
    begin
      if (pwr_q != LCD_ACT)
      begin
        dac_q <= `CUR_ZERO;
        rcnt_q <= 15'h0000;
      end
      else if (!ctrl_q)
        dac_q <= coil_q;
      else if (rcnt_q >= ramp_iv)
      begin
        rcnt_q <= 15'h0000;
        dac_q <= (coil_q > dac_q) ? dac_q + mv : dac_q - mv;
      end
      else
        rcnt_q <= rcnt_q + 15'h0001;
    end
  end

  // outputs
  assign drive_en  = pwr_q == LCD_ACT;
  assign lin_mode  = mode_q[`MODE_LIN_BIT];
  assign hs_on     = hs_q;
  assign ls_on     = ls_q;
  assign dac_code  = dac_q;
  assign sda_o     = 1'b0;
  assign sda_oe    = oe_q;
  assign pwr_state = pwr_q;

  sequence s_srst;
    wr_ev && (ptr_q == `REG_CTRL) && sh_q[`CTRL_RST_BIT];
  endsequence

  AST_SHDN_IN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && shdn_ev) |=> pwr_q == LCD_SHDN) else $error("no shutdown after scl low");
  AST_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && pwr_q == LCD_SHDN && scl_s) |=> (pwr_q == LCD_STBY && res_q == `RES_DEF))
    else $error("wake missed standby or defaults");
  AST_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pwr_q == LCD_SHDN && $past(pwr_q) == LCD_SHDN) |-> !oe_q) else $error("sda driven in shutdown");
  AST_ACT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && scl_s && pwr_q == LCD_STBY && coil_q != `CUR_ZERO && !tsd_s) |=> drive_en)
    else $error("nonzero setting did not activate");
  AST_STBY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && scl_s && pwr_q == LCD_ACT && coil_q == `CUR_ZERO) |=> pwr_q == LCD_STBY)
    else $error("zero setting stayed active");
  AST_SRST: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && scl_s) ##0 s_srst |=> (pwr_q != LCD_ACT && ctrl_q && mode_q == `MODE_DEF))
    else $error("soft reset incomplete");
  AST_FAULT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && scl_s && pwr_q == LCD_ACT && fault_s) |=> !drive_en) else $error("fault kept active");
  AST_FAULT_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !load_def && flt_clr) |=> coil_q == `CUR_ZERO) else $error("fault left setting");
  AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && go_act && evt_s == 5'h00) |=> stat_q == 5'h00) else $error("flags kept on activation");
  AST_SW_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ls_q) |-> $past(hs_q)) else $error("freewheel without high side phase");
  AST_PTR_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && wr_ev && !start_ev && !stop_ev) |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");
  AST_MSB_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && wr_ev && ptr_q == `REG_CMSB && !flt_clr && !load_def) |=> $stable(coil_q))
    else $error("high byte changed setting");

endmodule : lcd_ctl

// [lcd_i2c_mst.sv]
// i2c master model standing in for the host processor
`timescale 1ns/1ps
module lcd_i2c_mst #(
  parameter int HALF_NS = 1250
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // bus released, clock standing high between frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // start or repeated start: sda falls while scl high
  task automatic start();
    sda_low = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_low = 1'b0;
    #(HALF_NS);
  endtask : stop

  // one bus clock; data only moves while scl is low
  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS / 2);
    r = sda;
    #(HALF_NS / 2);
    scl = 1'b0;
  endtask : xbit

  // msb first, then the slave answers in the ninth clock
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte

  // last byte is refused so the slave lets go of the line
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, d[i]);
    xbit(last, r);
  endtask : rbyte

  // hold the clock at a level, used to park the bus
  task automatic park(input logic lvl);
    scl = lvl;
  endtask : park
endmodule : lcd_i2c_mst

// [lcd_pkg.sv]
// types shared by the lens coil driver control
package lcd_pkg;
  typedef enum logic [1:0] {
    LCD_SHDN = 2'h0,
    LCD_STBY = 2'h1,
    LCD_ACT  = 2'h3
  } lcd_pwr_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_RX   = 3'h1,
    I_ACKW = 3'h3,
    I_ACK  = 3'h2,
    I_TX   = 3'h6,
    I_TACK = 3'h7,
    I_NXT  = 3'h5
  } lcd_i2c_t;
endpackage : lcd_pkg

// [lcd_regs.svh]
// register offsets, field positions, defaults and timing counts
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
`define REG_CTRL       8'h02
`define REG_CMSB       8'h03
`define REG_CLSB       8'h04
`define REG_STAT       8'h05
`define REG_MODE       8'h06
`define REG_RES        8'h07
`define CTRL_RST_BIT   0
`define CTRL_RING_BIT  1
`define CTRL_DEF       1'b1
`define MODE_RMODE_BIT 0
`define MODE_LIN_BIT   1
`define MODE_FRQ       4:2
`define MODE_DEF       5'h00
`define RES_DEF        8'h83
`define CUR_ZERO       10'h000
`define BYTE_LAST      4'h7
`define BYTE_BITS      4'h8
`define BYTE_DATA      2'h2
`define CLK_MHZ        25
`define SHDN_NS        500000
`define SHDN_CYC       ((`SHDN_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_NS        100000
`define WAKE_CYC       ((`WAKE_NS * `CLK_MHZ) / 1000)
`define PWM_500K       6'h32
`define PWM_1M         6'h19
`define PWM_2M         6'h0C
`define PWM_4M         6'h06
`define PWM_4M8        6'h05
`define PWM_6M         6'h04
`define RES_OFS        9'h17F
`define RAMP_1X        6'h14
`define RAMP_2X        6'h28
`define RAMP_SHIFT     6
`endif

// [lens_coil_driver_control_tb.sv]
// self-checking bench for the lens coil driver control
`timescale 1ns/1ps
`include "lcd_regs.svh"
module lens_coil_driver_control_tb;
  import lcd_pkg::*;
  localparam int unsigned SHDN_T = 50;
  localparam logic [6:0]  ADDR   = 7'h0E;
  localparam logic [7:0]  DFLT [6] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h83};
  localparam logic [2:0]  PCODE [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam int          PRISE [4] = '{12, 24, 50, 100};
  logic            core_clk, rst_n, scl, sda_low, ot_f, sh_f, op_f, cur_above, ack, hs_prev;
  wire logic       sda, sda_o, sda_oe, drive_en, lin_mode, hs_on, ls_on;
  wire logic [9:0] dac_code;
  lcd_pwr_t        pwr_state;
  logic [7:0]      rd_q;
  int              error_cnt, checks_done, hs_rises, base;

  // open-drain wire with pull-up: low if either side pulls
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  lcd_ctl #(.SHDN_CYC(SHDN_T), .DEV_ADDR(ADDR)) lcd_ctl_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .scl_clk(scl), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .ot_fault_i(ot_f),
    .short_fault_i(sh_f), .open_fault_i(op_f), .uvlo_i(1'b0), .ovc_i(1'b0),
    .cur_above_i(cur_above), .drive_en(drive_en), .lin_mode(lin_mode), .hs_on(hs_on),
    .ls_on(ls_on), .dac_code(dac_code), .pwr_state(pwr_state)
  );

  lcd_i2c_mst lcd_i2c_mst_i (.scl(scl), .sda_low(sda_low), .sda(sda));

  always #20 core_clk = ~core_clk;

  // counts high-side switch turn-ons; sampled on the falling edge so the
  // registered output has settled and no race with its launching edge
  always @(negedge core_clk)
  begin
    hs_prev <= hs_on;
    if (hs_on && !hs_prev)
      hs_rises <= hs_rises + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] r, input logic [23:0] d, input int n);
    logic [1:0] a;
    logic       k;
    lcd_i2c_mst_i.start();
    lcd_i2c_mst_i.wbyte({ADDR, 1'b0}, a[0]);
    lcd_i2c_mst_i.wbyte(r, a[1]);
    for (int i = n - 1; i >= 0; i--)
      lcd_i2c_mst_i.wbyte(d[8*i +: 8], k);
    lcd_i2c_mst_i.stop();
    chk(16'({a, k}), 16'h7);
  endtask : wr

  // set_ptr low reads from wherever the pointer stands
  task automatic rd(input logic set_ptr, input logic [7:0] r, input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] d;
    a = 3'h7;
    if (set_ptr)
    begin
      lcd_i2c_mst_i.start();
      lcd_i2c_mst_i.wbyte({ADDR, 1'b0}, a[0]);
      lcd_i2c_mst_i.wbyte(r, a[1]);
    end
    lcd_i2c_mst_i.start();
    lcd_i2c_mst_i.wbyte({ADDR, 1'b1}, a[2]);
    lcd_i2c_mst_i.rbyte(1'b1, d);
    lcd_i2c_mst_i.stop();
    chk(16'(a), 16'h7);
    chk(16'(d), 16'(exp));
  endtask : rd

  task automatic wait_pwr(input lcd_pwr_t s, input int n);
    int i;
    i = 0;
    while (pwr_state !== s && i < n)
    begin
      @(negedge core_clk);
      i++;
    end
    chk(16'(pwr_state), 16'(s));
  endtask : wait_pwr

  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // watchdog: tests need about 2.9 ms, this stops a hang at 90k core cycles
  initial
  begin
    #3600000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    {core_clk, rst_n, ot_f, sh_f, op_f, cur_above, hs_prev} = 7'h00;
    {error_cnt, checks_done, hs_rises} = '0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    wait_pwr(LCD_STBY, `WAKE_CYC);
    repeat (10) @(negedge core_clk);
    // defaults in one sequential read from control to resonance
    lcd_i2c_mst_i.start();
    lcd_i2c_mst_i.wbyte({ADDR, 1'b0}, ack);
    lcd_i2c_mst_i.wbyte(`REG_CTRL, ack);
    lcd_i2c_mst_i.start();
    lcd_i2c_mst_i.wbyte({ADDR, 1'b1}, ack);
    for (int i = 0; i < 6; i++)
    begin
      lcd_i2c_mst_i.rbyte(i == 5, rd_q);
      chk(16'(rd_q), 16'(DFLT[i]));
    end
    lcd_i2c_mst_i.stop();
    // a foreign address gets no acknowledge
    lcd_i2c_mst_i.start();
    lcd_i2c_mst_i.wbyte({ADDR ^ 7'h01, 1'b0}, ack);
    lcd_i2c_mst_i.stop();
    chk(16'(ack), 16'h0);
    // 100 Hz lens: 383 - 19200/100 = 191
    wr(`REG_RES, 24'hBF, 1);
    rd(1'b1, `REG_RES, 8'hBF);
    wr(`REG_MODE, 24'h02, 1);
    rd(1'b0, 8'h00, 8'hBF);
    chk(16'(lin_mode), 16'h1);
    // high byte alone must not start the coil
    wr(`REG_CMSB, 24'h01, 1);
    chk(16'(pwr_state), 16'(LCD_STBY));
    wr(`REG_CLSB, 24'h23, 1);
    chk(16'(pwr_state), 16'(LCD_ACT));
    chk(16'(drive_en), 16'h1);
    chk(16'(dac_code < 10'h123), 16'h1);
    wr(`REG_CTRL, 24'h000245, 3);
    chk(16'(dac_code), 16'h0245);
    // switched stage: high side until the comparator trips
    wr(`REG_MODE, 24'h00, 1);
    chk(16'(lin_mode), 16'h0);
    repeat (60) @(negedge core_clk);
    chk(16'({hs_on, ls_on}), 16'h2);
    cur_above = 1'b1;
    for (int i = 0; i < 10 && ls_on !== 1'b1; i++)
      @(negedge core_clk);
    chk(16'({hs_on, ls_on}), 16'h1);
    foreach (PCODE[k])
    begin
      wr(`REG_MODE, 24'({PCODE[k], 2'b00}), 1);
      @(negedge core_clk);
      base = hs_rises;
      repeat (600) @(negedge core_clk);
      chk(16'((hs_rises - base) >= PRISE[k] - 1 && (hs_rises - base) <= PRISE[k] + 1), 16'h1);
    end
    // each fault drops to standby, clears setting, latches its flag
    for (int k = 0; k < 3; k++)
    begin
      @(negedge core_clk);
      {ot_f, sh_f, op_f} = 3'b100 >> k;
      wait_pwr(LCD_STBY, 10);
      chk(16'(drive_en), 16'h0);
      {ot_f, sh_f, op_f} = 3'b000;
      rd(1'b1, `REG_CLSB, 8'h00);
      rd(1'b1, `REG_STAT, 8'h10 >> k);
      wr(`REG_CLSB, 24'h45, 1);
      chk(16'(pwr_state), 16'(LCD_ACT));
    end
    rd(1'b1, `REG_STAT, 8'h00);
    wr(`REG_CMSB, 24'h0000, 2);
    chk(16'(pwr_state), 16'(LCD_STBY));
    chk(16'({drive_en, dac_code}), 16'h0000);
    // soft reset from active restores defaults
    wr(`REG_CLSB, 24'h45, 1);
    wr(`REG_RES, 24'h11, 1);
    wr(`REG_CTRL, 24'h01, 1);
    chk(16'(pwr_state), 16'(LCD_STBY));
    rd(1'b1, `REG_RES, 8'h83);
    rd(1'b1, `REG_CTRL, 8'h02);
    // clock held low: shutdown after the timeout, kept while low
    wr(`REG_RES, 24'h11, 1);
    @(negedge core_clk);
    lcd_i2c_mst_i.park(1'b0);
    repeat (SHDN_T - 5) @(negedge core_clk);
    chk(16'(pwr_state), 16'(LCD_STBY));
    wait_pwr(LCD_SHDN, 15);
    repeat (300) @(negedge core_clk);
    chk(16'(pwr_state), 16'(LCD_SHDN));
    lcd_i2c_mst_i.park(1'b1);
    wait_pwr(LCD_STBY, `WAKE_CYC);
    repeat (10) @(negedge core_clk);
    rd(1'b1, `REG_RES, 8'h83);
    finish_test();
  end
endmodule : lens_coil_driver_control_tb
